// ===== input_pin_noise_filter.sv
// input pin noise filter top with sampling clock select register on AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite register port.
`default_nettype none
module input_pin_noise_filter
	import noise_filter_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// axi4-lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// clock generator and port mode
	input  wire logic        periph_clk_run,
	input  wire logic [9:0]  alt_func_en,
	// raw pins
	input  wire logic        filtered_ext_irq_pin,
	input  wire logic        timer_a_capture_in0,
	input  wire logic        timer_a_capture_in1,
	input  wire logic        timer_a_capture_in2,
	input  wire logic        timer_a_capture_in3,
	input  wire logic        timer_a_event_in,
	input  wire logic        timer_b_capture_in20,
	input  wire logic        timer_b_capture_in21,
	input  wire logic        timer_b_capture_in00,
	input  wire logic        timer_b_capture_in01,
	// filtered levels to edge detection and timers
	output logic [9:0]       filt_level,
	// raw synchronised levels for port reads
	output logic [9:0]       port_level,
	// standby release qualification of the irq pin
	output logic             irq_pin_standby_release
);
	typedef struct packed {
		logic                   awready;
		logic                   wready;
		logic                   aw_got;
		logic                   aw_hit;
		logic                   w_got;
		logic [SEL_FIELD_W-1:0] w_sel;
		logic                   w_lane0;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [1:0]             rresp;
		logic [31:0]            rdata;
		logic [SEL_FIELD_W-1:0] sel;
		logic [DIV_CNT_W-1:0]   div_cnt;
		logic                   irq_strobe;
		logic                   tmr_strobe;
		logic                   release_ok;
	} top_state_t;

	// everything idle, select at divide-by-16
	localparam top_state_t TOP_RESET = '{
		awready:    1'b0,
		wready:     1'b0,
		aw_got:     1'b0,
		aw_hit:     1'b0,
		w_got:      1'b0,
		w_sel:      SEL_RESET,
		w_lane0:    1'b0,
		bvalid:     1'b0,
		bresp:      RESP_OKAY,
		arready:    1'b0,
		rvalid:     1'b0,
		rresp:      RESP_OKAY,
		rdata:      32'h0,
		sel:        SEL_RESET,
		div_cnt:    DIV_CNT_RESET,
		irq_strobe: 1'b0,
		tmr_strobe: 1'b0,
		release_ok: 1'b0
	};

	top_state_t s;
	top_state_t next_s;
	logic [9:0] pins_raw;
	logic [9:0] strobes;

	// the pin vectors are sized for ten inputs with the irq pin at bit zero
	if (PIN_COUNT != 10 || IRQ_PIN_IDX != 0)
	begin : g_bad_pin_map
		$error("input_pin_noise_filter: pin map needs ten pins with the irq pin first");
	end

	function automatic logic addr_hit(input logic [31:0] addr);
		addr_hit = (addr == SEL_REG_ADDR);
	endfunction

	// low bits of the divider that must be all ones for a sampling edge
	function automatic logic [DIV_CNT_W-1:0] div_mask(input logic [SEL_FIELD_W-1:0] code);
		unique case (code)
			SEL_DIV16: div_mask = 4'hf;
			SEL_DIV8:  div_mask = 4'h7;
			SEL_DIV4:  div_mask = 4'h3;
			SEL_DIV2:  div_mask = 4'h1;
		endcase
	endfunction

	always_comb
	begin
		next_s = s;
		// write channels taken independently
		if (s_axi_awvalid && s.awready)
		begin
			next_s.aw_got = 1'b1;
			next_s.aw_hit = addr_hit(s_axi_awaddr);
		end
		if (s_axi_wvalid && s.wready)
		begin
			next_s.w_got   = 1'b1;
			next_s.w_sel   = s_axi_wdata[SEL_FIELD_LSB +: SEL_FIELD_W];
			next_s.w_lane0 = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		// answer once both halves are in, no new write is taken until it is accepted
		if (s.aw_got && s.w_got && !s.bvalid)
		begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = s.aw_hit ? RESP_OKAY : RESP_DECERR;
			if (s.aw_hit && s.w_lane0)
				next_s.sel = s.w_sel;
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready  = !next_s.w_got && !next_s.bvalid;
		// read channel
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		if (s_axi_arvalid && s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
			next_s.rdata  = addr_hit(s_axi_araddr) ? {30'h0, s.sel} : 32'h0;
		end
		next_s.arready = !next_s.rvalid;
		// sampling clocks, frozen while the peripheral clock stands
		if (periph_clk_run)
			next_s.div_cnt = s.div_cnt + 4'h1;
		next_s.irq_strobe = periph_clk_run
			&& ((s.div_cnt & div_mask(s.sel)) == div_mask(s.sel));
		next_s.tmr_strobe = periph_clk_run;
		// the clock-sampled pin is never a standby release source
		next_s.release_ok = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s <= TOP_RESET;
		else
			s <= next_s;
	end

	// bit 0 is the irq pin, the rest are timer inputs
	assign pins_raw[0] = filtered_ext_irq_pin;
	assign pins_raw[1] = timer_a_capture_in0;
	assign pins_raw[2] = timer_a_capture_in1;
	assign pins_raw[3] = timer_a_capture_in2;
	assign pins_raw[4] = timer_a_capture_in3;
	assign pins_raw[5] = timer_a_event_in;
	assign pins_raw[6] = timer_b_capture_in20;
	assign pins_raw[7] = timer_b_capture_in21;
	assign pins_raw[8] = timer_b_capture_in00;
	assign pins_raw[9] = timer_b_capture_in01;
	assign strobes = {{(PIN_COUNT-1){s.tmr_strobe}}, s.irq_strobe};

	for (genvar i = 0; i < PIN_COUNT; i++)
	begin : g_cell
		noise_filter_cell #(
			.ACCEPT_COUNT (FILTER_ACCEPT)
		) u_cell (
			.clk           (clk),
			.rst_n         (rst_n),
			.pin_raw       (pins_raw[i]),
			.sample_strobe (strobes[i]),
			.alt_func_en   (alt_func_en[i]),
			.port_level    (port_level[i]),
			.filt_level    (filt_level[i])
		);
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rresp   = s.rresp;
	assign s_axi_rdata   = s.rdata;
	assign irq_pin_standby_release = s.release_ok;
endmodule
`default_nettype wire

// ===== noise_filter_pkg.sv
// constants shared by the input pin noise filter files
`default_nettype none
package noise_filter_pkg;
	localparam logic [31:0] SEL_REG_ADDR     = 32'hfffff310;
	localparam int          SEL_FIELD_LSB    = 0;
	localparam int          SEL_FIELD_W      = 2;
	localparam logic [1:0]  SEL_RESET        = 2'h0;
	localparam logic [1:0]  SEL_DIV16        = 2'h0;
	localparam logic [1:0]  SEL_DIV8         = 2'h1;
	localparam logic [1:0]  SEL_DIV4         = 2'h2;
	localparam logic [1:0]  SEL_DIV2         = 2'h3;
	localparam int          FILTER_ACCEPT    = 5;
	localparam int          DIV_CNT_W        = 4;
	localparam logic [3:0]  DIV_CNT_RESET    = 4'h0;
	localparam int          PIN_COUNT        = 10;
	localparam int          IRQ_PIN_IDX      = 0;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_DECERR      = 2'h3;
endpackage
`default_nettype wire

// ===== noise_filter_cell.sv
// one synchroniser plus five-in-a-row digital noise filter
`default_nettype none
module noise_filter_cell
	import noise_filter_pkg::*;
#(
	parameter int ACCEPT_COUNT = FILTER_ACCEPT
)
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// pin side
	input  wire logic pin_raw,
	input  wire logic sample_strobe,
	input  wire logic alt_func_en,
	// user side
	output logic      port_level,
	output logic      filt_level
);
	// the counter is three bits wide, so only 2..8 samples can be served
	if (ACCEPT_COUNT < 2 || ACCEPT_COUNT > 8)
	begin : g_bad_count
		$error("noise_filter_cell: ACCEPT_COUNT must be 2..8");
	end

	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       filt;
		logic [2:0] cnt;
	} cell_state_t;

	localparam cell_state_t CELL_RESET = '{sync1: 1'b0, sync2: 1'b0, filt: 1'b0, cnt: 3'h0};

	cell_state_t s;
	cell_state_t next_s;

	always_comb
	begin
		next_s = s;
		next_s.sync1 = pin_raw;
		next_s.sync2 = s.sync1;
		if (!alt_func_en)
			next_s.cnt = 3'h0;
		else if (sample_strobe)
		begin
			if (s.sync2 != s.filt)
			begin
				if (s.cnt == 3'(ACCEPT_COUNT - 1))
				begin
					next_s.filt = s.sync2;
					next_s.cnt  = 3'h0;
				end
				else
					next_s.cnt = s.cnt + 3'h1;
			end
			else
				next_s.cnt = 3'h0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s <= CELL_RESET;
		else
			s <= next_s;
	end

	assign port_level = s.sync2;
	assign filt_level = s.filt;
endmodule
`default_nettype wire

// ===== pin_board.sv
// board model driving the raw input pins
`default_nettype none
module pin_board
(
	input  wire logic [9:0] level,
	output logic      [9:0] pins
);
	timeunit 1ns / 1ps;
	// levels are held by the bench for whole clock cycles, never shorter than asked
	assign pins = level;
endmodule
`default_nettype wire

// ===== input_pin_noise_filter_props.sv
// assertions on the noise filter top ports
`default_nettype none
module input_pin_noise_filter_props
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       periph_clk_run,
	input wire logic [9:0] alt_func_en,
	input wire logic       timer_a_capture_in0,
	input wire logic [9:0] filt_level,
	input wire logic [9:0] port_level,
	input wire logic       irq_pin_standby_release
);
	timeunit 1ns / 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// timer pin steady and filtering allowed for eight cycles
	sequence held1;
		(alt_func_en[1] && periph_clk_run && $stable(port_level[1])) [*8];
	endsequence
	a_no_wake: assert property (!irq_pin_standby_release) else $error("wake set");
	a_timer_run: assert property
		($changed(filt_level[1]) |-> $past(port_level[1], 4) == filt_level[1]) else $error("early");
	a_timer_pass: assert property
		(held1 |-> filt_level[1] == port_level[1]) else $error("not taken");
	a_port_raw: assert property
		($past(rst_n) && $past(rst_n, 2) |-> port_level[1] == $past(timer_a_capture_in0, 2))
		else $error("port level");
	a_clk_stop: assert property
		((!periph_clk_run) [*2] |=> $stable(filt_level)) else $error("clock stop");
	a_port_mode: assert property
		((alt_func_en == 10'h0) [*2] |=> $stable(filt_level)) else $error("port mode");
	a_irq_slow: assert property
		($changed(filt_level[0]) |-> $past(port_level[0], 6) == filt_level[0]) else $error("irq");
	a_hold_same: assert property
		(port_level[1] == filt_level[1] |=> $stable(filt_level[1])) else $error("hold");
endmodule
bind input_pin_noise_filter input_pin_noise_filter_props props (.clk(clk), .rst_n(rst_n),
	.periph_clk_run(periph_clk_run), .alt_func_en(alt_func_en), .filt_level(filt_level),
	.timer_a_capture_in0(timer_a_capture_in0), .port_level(port_level),
	.irq_pin_standby_release(irq_pin_standby_release));
`default_nettype wire

// ===== tb.sv
// self-checking bench for the input pin noise filter
`default_nettype none
module tb import noise_filter_pkg::*;;
	timeunit 1ns / 1ps;
	logic clk = 0, rst_n = 0, run = 1, aw = 0, wv = 0, br = 0, ar = 0, rr = 0;
	logic awr, wr, bv, arr, rv, stby;
	logic [31:0] adr = 0, wd = 0, rdata;
	logic [1:0] bresp, rresp;
	logic [9:0] alt = 10'h3ff, lvl = 10'h0, filt, port;
	wire logic [9:0] p;
	int mismatches = 0, cmp_count = 0;
	always #2.5 clk = ~clk;
	pin_board brd (.level(lvl), .pins(p));
	input_pin_noise_filter dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(adr), .s_axi_awvalid(aw),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(adr), .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .periph_clk_run(run),
		.alt_func_en(alt), .filtered_ext_irq_pin(p[0]), .timer_a_capture_in0(p[1]),
		.timer_a_capture_in1(p[2]), .timer_a_capture_in2(p[3]), .timer_a_capture_in3(p[4]),
		.timer_a_event_in(p[5]), .timer_b_capture_in20(p[6]), .timer_b_capture_in21(p[7]),
		.timer_b_capture_in00(p[8]), .timer_b_capture_in01(p[9]), .filt_level(filt),
		.port_level(port), .irq_pin_standby_release(stby));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		mismatches += int'(got !== exp);
		if (got !== exp)
			$display("FAIL %0t got %h want %h", $time, got, exp);
	endtask
	// one register access, write when w is high
	task automatic acc(input logic w, input logic [31:0] a, d, input logic [1:0] r);
		@(posedge clk);
		adr <= a;
		wd <= d;
		{aw, wv, br, ar, rr} <= {w, w, w, !w, !w};
		do
		begin
			@(posedge clk);
			{aw, wv, ar} <= {aw && !awr, wv && !wr, ar && !arr};
			if (w ? bv : rv)
			begin
				if (!w)
					chk(rdata, d);
				chk({30'h0, w ? bresp : rresp}, {30'h0, r});
				{br, rr} <= 2'h0;
			end
		end
		while (br || rr);
	endtask
	// drive one pin level, wait n cycles, compare its filtered level
	task automatic pin(input int b, input logic v, input int n, input logic e);
		@(posedge clk);
		lvl[b] <= v;
		repeat (n) @(posedge clk);
		chk({31'h0, filt[b]}, {31'h0, e});
	endtask
	task automatic end_of_test;
		if (mismatches == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		acc(1, 32'h0, 32'h3, RESP_DECERR);
		acc(0, SEL_REG_ADDR, 32'h0, RESP_OKAY);
		acc(0, 32'h4, 32'h0, RESP_DECERR);
		for (int b = 1; b < 10; b++)
		begin
			pin(b, 1, 3, 0);
			pin(b, 0, 12, 0);
			pin(b, 1, 12, 1);
			pin(b, 0, 12, 0);
		end
		alt <= 10'h0;
		pin(1, 1, 12, 0);
		chk({31'h0, port[1]}, 32'h1);
		alt <= 10'h3ff;
		pin(1, 0, 12, 0);
		run <= 1'b0;
		pin(2, 1, 20, 0);
		run <= 1'b1;
		pin(2, 0, 12, 0);
		for (int c = 0; c < 4; c++)
		begin
			acc(1, SEL_REG_ADDR, 32'(c), RESP_OKAY);
			acc(0, SEL_REG_ADDR, 32'(c), RESP_OKAY);
			pin(0, 1, 63 >> c, 0);
			pin(0, 0, 128 >> c, 0);
			pin(0, 1, 128 >> c, 1);
			pin(0, 0, 128 >> c, 0);
		end
		chk({31'h0, stby}, 32'h0);
		end_of_test();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
